//--- src/sarcc_pkg.sv
// constants shared by the converter control block
// assumes a byte-addressed bus with one aligned word per register
package sarcc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] SARCC_IDX_RES_LO = 8'h78;
	localparam logic [7:0] SARCC_IDX_RES_HI = 8'h79;
	localparam logic [7:0] SARCC_IDX_CTRL = 8'h7A;
	localparam logic [7:0] SARCC_IDX_CTRL_B = 8'h7B;
	localparam logic [7:0] SARCC_IDX_CHSEL = 8'h7C;
	localparam logic [7:0] SARCC_REG_RST = 8'h00;
	// control and status bit positions
	localparam int SARCC_EN = 7;
	localparam int SARCC_START = 6;
	localparam int SARCC_ATE = 5;
	localparam int SARCC_FLAG = 4;
	localparam int SARCC_IE = 3;
	// channel and reference select bit positions
	localparam int SARCC_LEFT = 5;
	localparam int SARCC_CH_RSVD = 4;
	// conversion lengths in converter clocks
	localparam int SARCC_FIRST_LEN = 25;
	localparam int SARCC_NORM_LEN = 13;
	localparam logic [4:0] SARCC_FIRST_LAST = 5'(SARCC_FIRST_LEN - 1);
	localparam logic [4:0] SARCC_NORM_LAST = 5'(SARCC_NORM_LEN - 1);
	// channel, reference and trigger source codes
	localparam logic [3:0] SARCC_CH_TEMP = 4'h8;
	localparam logic [3:0] SARCC_CH_BGAP = 4'hE;
	localparam logic [3:0] SARCC_CH_GND = 4'hF;
	localparam logic [1:0] SARCC_REF_PIN = 2'h0;
	localparam logic [1:0] SARCC_REF_SUPPLY = 2'h1;
	localparam logic [1:0] SARCC_REF_INT = 2'h3;
	localparam logic [2:0] SARCC_TS_FREE = 3'h0;
	typedef enum logic {SARCC_IDLE, SARCC_CONV} sarcc_state_e;
endpackage

//--- src/sarcc_top.sv
// converter control, status and result registers on an avalon-mm slave
// assumes a converter core that samples on start and presents its code
// by the time the counted converter clocks have elapsed
`timescale 1ns/1ps
module sarcc_top import sarcc_pkg::*; #(
	parameter int RES_W = 10,
	parameter int TRIG_N = 7
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [9:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	input wire logic [TRIG_N-1:0] trig_flags_i,
	input wire logic global_irq_en_i,
	input wire logic irq_ack_i,
	input wire logic [RES_W-1:0] core_code_i,
	output logic core_power_o,
	output logic core_start_o,
	output logic [3:0] core_channel_o,
	output logic [1:0] core_reference_o,
	output logic temp_sensor_en_o,
	output logic conv_tick_o,
	output logic irq_o
);
	// elaboration check: logic is laid out for a 10-bit code, 7 sources
	if (RES_W != 10 || TRIG_N != 7) begin : g_chk
		$error("sarcc_top: only RES_W=10 and TRIG_N=7 supported");
	end

	// register state
	logic en;
	logic ate;
	logic ie;
	logic flag;
	logic [2:0] ps;
	logic [2:0] tsrc;
	logic [7:0] chsel;
	logic [9:0] res;
	logic lock;
	logic init_pend;
	logic init_run;
	logic [6:0] pre_cnt;
	logic [4:0] conv_cnt;
	logic trig_prev;
	sarcc_state_e state;
	sarcc_state_e next_state;
	logic next_wait;
	logic [7:0] next_rdata;

	// bus decode
	wire req = read_i | write_i;
	wire acc = req & !waitrequest_o;
	wire wr_acc = acc & write_i & byteenable_i[0];
	wire rd_acc = acc & read_i;
	wire sel_lo = address_i == {SARCC_IDX_RES_LO, 2'b00};
	wire sel_hi = address_i == {SARCC_IDX_RES_HI, 2'b00};
	wire sel_ctrl = address_i == {SARCC_IDX_CTRL, 2'b00};
	wire sel_ctrlb = address_i == {SARCC_IDX_CTRL_B, 2'b00};
	wire sel_ch = address_i == {SARCC_IDX_CHSEL, 2'b00};
	wire [7:0] wd = writedata_i[7:0];
	wire wr_ctrl = wr_acc & sel_ctrl;
	wire wr_ctrlb = wr_acc & sel_ctrlb;
	wire wr_ch = wr_acc & sel_ch;
	wire rd_lo = rd_acc & sel_lo;
	wire rd_hi = rd_acc & sel_hi;

	// status
	wire idle = state == SARCC_IDLE;
	wire busy = state == SARCC_CONV;
	wire left = chsel[SARCC_LEFT];

	// result presentation follows the align bit at once
	wire [7:0] lo_view = left ? {res[1:0], 6'h00} : res[7:0];
	wire [7:0] hi_view = left ? res[9:2] : {6'h00, res[9:8]};
	wire [7:0] ctrl_view = {en, busy, ate, flag, ie, ps};
	wire [7:0] ch_view = chsel & ~(8'h01 << SARCC_CH_RSVD);

	// read mux; unmapped addresses read zero
	assign next_rdata = sel_lo ? lo_view :
		sel_hi ? hi_view :
		sel_ctrl ? ctrl_view :
		sel_ctrlb ? {5'h00, tsrc} :
		sel_ch ? ch_view : 8'h00;
	// one wait state, then a single answer cycle
	assign next_wait = !(waitrequest_o & req);

	// trigger selection; code 000 gives no edge at all
	wire [7:0] trig_all = {trig_flags_i, 1'b0}; // code 000 has no flag
	wire trig_sel = trig_all[tsrc];
	wire trig_edge = trig_sel & !trig_prev;
	wire free_run = ate & (tsrc == SARCC_TS_FREE);

	// prescaler: divide by 2^k with k at least one
	wire [2:0] k = (ps < 3'd2) ? 3'd1 : ps;
	wire [6:0] mask = 7'((8'h01 << k) - 8'h01);
	wire tick = (pre_cnt & mask) == mask;

	// conversion sequencing
	wire [4:0] last = init_run ? SARCC_FIRST_LAST : SARCC_NORM_LAST;
	wire conv_end = busy & tick & (conv_cnt == last);
	wire en_new = wr_ctrl ? wd[SARCC_EN] : en;
	wire start_wr = wr_ctrl & wd[SARCC_START];
	wire auto_go = ate & en & trig_edge;
	wire start_go = idle & en_new & (start_wr | auto_go);
	wire restart = conv_end & free_run & en_new;
	wire launch = start_go | restart;
	wire flag_clr = irq_ack_i | (wr_ctrl & wd[SARCC_FLAG]);

	// next state: enable low aborts, a finished run idles or restarts
	always_comb begin
		next_state = state;
		unique case (state)
			SARCC_IDLE: begin
				if (start_go) begin
					next_state = SARCC_CONV;
				end
			end
			SARCC_CONV: begin
				if (!en_new) begin
					next_state = SARCC_IDLE;
				end else if (conv_end && !restart) begin
					next_state = SARCC_IDLE;
				end
			end
		endcase
	end

	// bus slave handshake and read data
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			waitrequest_o <= 1'b1;
			readdata_o <= 32'h0000_0000;
		end else begin
			waitrequest_o <= next_wait;
			readdata_o <= {24'h00_0000, next_rdata};
		end
	end

	// control and status register
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			en <= 1'b0;
			ate <= 1'b0;
			ie <= 1'b0;
			ps <= 3'h0;
		end else if (wr_ctrl) begin
			en <= wd[SARCC_EN];
			ate <= wd[SARCC_ATE];
			ie <= wd[SARCC_IE];
			ps <= wd[2:0];
		end
	end

	// second control register and channel/reference select
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			tsrc <= 3'h0;
			chsel <= SARCC_REG_RST;
		end else begin
			if (wr_ctrlb) begin
				tsrc <= wd[2:0];
			end
			if (wr_ch) begin
				chsel <= wd;
			end
		end
	end

	// completion flag: a set in the clearing cycle wins
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			flag <= 1'b0;
		end else if (conv_end) begin
			flag <= 1'b1;
		end else if (flag_clr) begin
			flag <= 1'b0;
		end
	end

	// result and byte-pair lock
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			res <= 10'h000;
			lock <= 1'b0;
		end else begin
			if (conv_end && !lock) begin
				res <= core_code_i;
			end
			if (rd_lo) begin
				lock <= 1'b1;
			end else if (rd_hi) begin
				lock <= 1'b0;
			end
		end
	end

	// first-run marker armed while enable is low, spent by a launch
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			init_pend <= 1'b0;
			init_run <= 1'b0;
		end else begin
			if (!en_new) begin
				init_pend <= 1'b1;
			end else if (launch) begin
				init_pend <= 1'b0;
			end
			if (launch) begin
				init_run <= init_pend | !en;
			end
		end
	end

	// sequencer, prescaler and run counter; prescaler restarts on launch
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= SARCC_IDLE;
			pre_cnt <= 7'h00;
			conv_cnt <= 5'h00;
			trig_prev <= 1'b0;
		end else begin
			state <= next_state;
			trig_prev <= trig_sel;
			if (launch || !en) begin
				pre_cnt <= 7'h00;
			end else begin
				pre_cnt <= pre_cnt + 7'h01;
			end
			if (launch) begin
				conv_cnt <= 5'h00;
			end else if (busy && tick) begin
				conv_cnt <= conv_cnt + 5'h01;
			end
		end
	end

	// settings are frozen into the core at each launch
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			core_channel_o <= 4'h0;
			core_reference_o <= 2'h0;
			temp_sensor_en_o <= 1'b0;
		end else if (launch) begin
			core_channel_o <= chsel[3:0];
			core_reference_o <= chsel[7:6];
			temp_sensor_en_o <= chsel[3:0] == SARCC_CH_TEMP;
		end
	end

	// core strobes and interrupt request
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			core_power_o <= 1'b0;
			core_start_o <= 1'b0;
			conv_tick_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			core_power_o <= en_new;
			core_start_o <= launch;
			conv_tick_o <= busy & tick & en_new;
			irq_o <= flag & ie & global_irq_en_i;
		end
	end

	// checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	a_result_update: assert property (
		conv_end && !lock |=> res == $past(core_code_i))
		else $error("result not loaded at completion");
	a_flag_sets: assert property (
		conv_end |=> flag)
		else $error("flag did not set at completion");
	a_irq_gate: assert property (
		irq_o |-> $past(flag) && $past(ie) && $past(global_irq_en_i))
		else $error("interrupt without all enables");
	a_flag_zero_write: assert property (
		flag && wr_ctrl && !wd[SARCC_FLAG] && !irq_ack_i |=> flag)
		else $error("writing zero cleared the flag");
	a_disable_aborts: assert property (
		busy && wr_ctrl && !wd[SARCC_EN] |=> idle ##1 !core_power_o[*2])
		else $error("disable did not abort");
	a_start_busy: assert property (
		start_go |=> busy && core_start_o ##1 !core_start_o)
		else $error("start write did not begin run");
	a_temp_route: assert property (
		launch && chsel[3:0] == SARCC_CH_TEMP |=> temp_sensor_en_o)
		else $error("temperature sensor not enabled");
	a_lock_holds: assert property (
		lock && conv_end |=> $stable(res))
		else $error("locked result changed");
	a_settings_frozen: assert property (
		busy && !launch |=> $stable(core_channel_o))
		else $error("channel changed mid run");
	a_run_length: assert property (
		conv_end |-> conv_cnt == (init_run ? 5'd24 : 5'd12))
		else $error("wrong conversion length");
	a_free_no_trig: assert property (
		idle && ate && tsrc == SARCC_TS_FREE && !start_wr |=> idle)
		else $error("free run mode started without a start write");

	// bus handshake: one wait state, then one answer cycle
	a_one_wait: assert property (
		!waitrequest_o |=> waitrequest_o)
		else $error("answer cycle lasted more than one clock");
	a_answer_next: assert property (
		waitrequest_o && req |=> !waitrequest_o)
		else $error("request not answered after one wait");

	// run control: long first run, starts, flag clearing, power, sensor routing, tick spacing
	a_first_long: assert property (
		launch && !en |=> init_run)
		else $error("run started with enabling is not long");
	a_zero_start: assert property (
		idle && wr_ctrl && !wd[SARCC_START] && !auto_go |=> idle)
		else $error("writing zero to start began a run");
	a_flag_ack: assert property (
		flag && irq_ack_i && !conv_end |=> !flag)
		else $error("vector taken did not clear flag");
	a_auto_start: assert property (
		idle && auto_go && en_new |=> busy && core_start_o)
		else $error("trigger edge did not start a run");
	a_power_off: assert property (
		!en_new |=> !core_power_o)
		else $error("converter still powered after disable");
	a_temp_only: assert property (
		launch && chsel[3:0] != SARCC_CH_TEMP |=> !temp_sensor_en_o)
		else $error("temperature sensor enabled on other channel");
	a_tick_spacing: assert property (
		conv_tick_o && ps < 3'h2 |=> !conv_tick_o)
		else $error("converter clock faster than divide by two");

	c_single_run: cover property (start_go ##[1:1000] conv_end);
	c_free_restart: cover property (restart);
	c_locked_drop: cover property (lock && conv_end);
	c_auto_start: cover property (idle && auto_go);
	c_abort: cover property (busy && wr_ctrl && !wd[SARCC_EN]);
endmodule

//--- dv/sarcc_core_model.sv
// behavioural converter core facing the control block
// assumes one start pulse per launch and tick pulses during a run
`timescale 1ns/1ps
module sarcc_core_model (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic tick_i,
	input wire logic [3:0] channel_i,
	input wire logic [1:0] reference_i,
	output logic [9:0] code_o
);
	logic [9:0] held;
	logic [4:0] count;
	// code built from the launched settings, counted by ticks
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			held <= 10'h000;
			count <= 5'h1F;
		end else if (start_i) begin
			held <= {reference_i, channel_i, 4'h5};
			count <= 5'h00;
		end else if (tick_i && count != 5'h1F) begin
			count <= count + 5'h01;
		end
	end
	// past the longest run the code is gone, so show its inverse
	assign code_o = (count < 5'h1A) ? held : ~held;
endmodule

//--- dv/test_sarcc_top.sv
// self-checking bench for the converter control block
// assumes the core model above and pre-edge sampling at rising edges
`timescale 1ns/1ps
module test_sarcc_top import sarcc_pkg::*;;
	localparam logic [9:0] A_LO = {SARCC_IDX_RES_LO, 2'b00};
	localparam logic [9:0] A_HI = {SARCC_IDX_RES_HI, 2'b00};
	localparam logic [9:0] A_CT = {SARCC_IDX_CTRL, 2'b00};
	localparam logic [9:0] A_TS = {SARCC_IDX_CTRL_B, 2'b00};
	localparam logic [9:0] A_CH = {SARCC_IDX_CHSEL, 2'b00};
	logic clock_i, rst_i, read_i, write_i, waitrequest_o, global_irq_en_i;
	logic irq_ack_i, core_power_o, core_start_o, temp_sensor_en_o;
	logic conv_tick_o, irq_o;
	logic [9:0] address_i, core_code_i;
	logic [31:0] writedata_i, readdata_o;
	logic [3:0] byteenable_i, core_channel_o;
	logic [6:0] trig_flags_i;
	logic [1:0] core_reference_o;
	logic [7:0] q;
	int num_errors, checks_done, ticks, first, last, cyc;
	sarcc_top sarcc_top_i (.clock_i(clock_i), .rst_i(rst_i),
		.address_i(address_i), .read_i(read_i), .write_i(write_i),
		.writedata_i(writedata_i), .byteenable_i(byteenable_i),
		.readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.trig_flags_i(trig_flags_i), .global_irq_en_i(global_irq_en_i),
		.irq_ack_i(irq_ack_i), .core_code_i(core_code_i),
		.core_power_o(core_power_o), .core_start_o(core_start_o),
		.core_channel_o(core_channel_o), .core_reference_o(core_reference_o),
		.temp_sensor_en_o(temp_sensor_en_o), .conv_tick_o(conv_tick_o),
		.irq_o(irq_o));
	sarcc_core_model sarcc_core_model_i (.clock_i(clock_i), .rst_i(rst_i),
		.start_i(core_start_o), .tick_i(conv_tick_o),
		.channel_i(core_channel_o), .reference_i(core_reference_o),
		.code_o(core_code_i));
	// clock and tick bookkeeping
	always #50 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cyc = cyc + 1;
		if (conv_tick_o === 1'b1) begin
			if (ticks == 0) first = cyc;
			ticks = ticks + 1;
			last = cyc;
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [9:0] a,
		input logic [7:0] d, output logic [7:0] r);
		int n;
		n = 0;
		@(posedge clock_i);
		address_i <= a;
		writedata_i <= {24'h000000, d};
		write_i <= wr;
		read_i <= !wr;
		do begin
			@(posedge clock_i);
			n++;
		end while (waitrequest_o !== 1'b0 && n < 50);
		if (n >= 50) num_errors++;
		r = readdata_o[7:0];
		read_i <= 1'b0;
		write_i <= 1'b0;
	endtask
	// wait for completion, then judge tick count and spacing
	task automatic wait_done(input int len, input int div);
		int n;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (!(irq_o === 1'b1 && ticks > 0) && n < 4000);
		if (n >= 4000) num_errors++;
		chk(16'(ticks), 16'(len));
		chk(16'(last - first), 16'((len - 1) * div));
	endtask
	task automatic conv(input logic [7:0] ctl, input int len, input int div);
		ticks = 0;
		bus(1'b1, A_CT, ctl, q);
		wait_done(len, div);
	endtask
	task automatic s_reset;
		logic [9:0] a [6];
		a = '{A_LO, A_HI, A_CT, A_TS, A_CH, 10'h3FC};
		foreach (a[i]) begin
			bus(1'b0, a[i], 8'h00, q);
			chk(q, 8'h00);
		end
		chk(core_power_o, 1'b0);
	endtask
	task automatic s_first;
		bus(1'b1, A_CH, 8'hC3, q);
		ticks = 0;
		bus(1'b1, A_CT, 8'hC8, q);
		bus(1'b0, A_CT, 8'h00, q);
		chk(q[SARCC_START], 1'b1);
		bus(1'b1, A_CH, 8'h4F, q);
		chk(core_channel_o, 4'h3);
		wait_done(25, 2);
		chk(core_reference_o, SARCC_REF_INT);
		bus(1'b0, A_LO, 8'h00, q);
		chk(q, 8'h35);
		bus(1'b0, A_HI, 8'h00, q);
		chk(q, 8'h03);
		bus(1'b1, A_CH, 8'h23, q);
		bus(1'b0, A_LO, 8'h00, q);
		chk(q, 8'h40);
		bus(1'b0, A_HI, 8'h00, q);
		chk(q, 8'hCD);
		bus(1'b0, A_CT, 8'h00, q);
		chk(q, 8'h98);
	endtask
	task automatic s_irq;
		bus(1'b1, A_CT, 8'h88, q);
		bus(1'b0, A_CT, 8'h00, q);
		chk(q[SARCC_FLAG], 1'b1);
		global_irq_en_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		chk(irq_o, 1'b0);
		global_irq_en_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		chk(irq_o, 1'b1);
		irq_ack_i <= 1'b1;
		@(posedge clock_i);
		irq_ack_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		chk(irq_o, 1'b0);
	endtask
	task automatic s_divs;
		int dv [8];
		dv = '{2, 2, 4, 8, 16, 32, 64, 128};
		bus(1'b1, A_CH, 8'hC8, q);
		for (int p = 0; p < 8; p++) begin
			conv(8'hD8 | 8'(p), 13, dv[p]);
		end
		chk(temp_sensor_en_o, 1'b1);
	endtask
	task automatic s_lock;
		bus(1'b0, A_LO, 8'h00, q);
		chk(q, 8'h85);
		bus(1'b1, A_CH, 8'h02, q);
		conv(8'hD8, 13, 2);
		bus(1'b0, A_HI, 8'h00, q);
		chk(q, 8'h03);
		bus(1'b0, A_LO, 8'h00, q);
		chk(q, 8'h85);
	endtask
	task automatic s_abort;
		bus(1'b1, A_CT, 8'hD8, q);
		bus(1'b1, A_CT, 8'h00, q);
		bus(1'b0, A_CT, 8'h00, q);
		chk(q[SARCC_START], 1'b0);
		chk(core_power_o, 1'b0);
		conv(8'hD8, 25, 2);
	endtask
	task automatic s_trig;
		bus(1'b1, A_TS, 8'h01, q);
		ticks = 0;
		bus(1'b1, A_CT, 8'hB8, q);
		trig_flags_i <= 7'h01;
		wait_done(13, 2);
		trig_flags_i <= 7'h00;
	endtask
	// free running: switching to it starts nothing, a start write begins runs that relaunch on completion
	task automatic s_free;
		bus(1'b1, A_TS, 8'h00, q);
		bus(1'b0, A_CT, 8'h00, q);
		chk(q[SARCC_START], 1'b0);
		conv(8'hF8, 13, 2);
		bus(1'b0, A_CT, 8'h00, q);
		chk(q[SARCC_START], 1'b1);
	endtask
	task automatic report_and_stop;
		if (num_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		#(100 * 20000);
		num_errors++;
		report_and_stop();
	end
	// reset, then the scenarios in turn
	initial begin
		{clock_i, read_i, write_i, irq_ack_i, cyc, ticks} = '0;
		{num_errors, checks_done, first, last} = '0;
		{address_i, writedata_i, trig_flags_i} = '0;
		byteenable_i = 4'hF;
		global_irq_en_i = 1'b1;
		rst_i = 1'b1;
		repeat (3) @(posedge clock_i);
		rst_i <= 1'b0;
		s_reset();
		s_first();
		s_irq();
		s_divs();
		s_lock();
		s_abort();
		s_trig();
		s_free();
		report_and_stop();
	end
endmodule
